// ===== bench/icb_bridge_properties.sv
// Port checks of the serial command bridge
module icb_bridge_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe_n,
  input wire logic line_busy_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ------------------------------------------------
  // Busy length counter: a hung engine never drops busy
  // ------------------------------------------------
  logic [16:0] busy_cnt_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_r <= 17'h0;
    end else begin
      busy_cnt_r <= line_busy_flag ? busy_cnt_r + 17'h1 : 17'h0;
    end
  end

  // ------------------------------------------------
  // Steps of an accepted operation
  // ------------------------------------------------
  sequence s_ack_seen;
    ##[0:200] !sda_oe_n;
  endsequence
  sequence s_line_pull;
    ##[1:300] !line_oe_n;
  endsequence

  a_op_acked: assert property ($rose(line_busy_flag) |-> s_ack_seen)
    else $error("line operation began without acknowledge");
  a_line_drive: assert property ($rose(line_busy_flag) |-> s_line_pull)
    else $error("line operation never pulled the line");
  a_line_owned: assert property (!line_oe_n |-> line_busy_flag)
    else $error("line pulled while not busy");
  a_pull_width: assert property ($fell(line_oe_n) |-> !line_oe_n [*8])
    else $error("line pull shorter than eight cycles");
  a_busy_bound: assert property (busy_cnt_r < 17'd100000)
    else $error("busy flag stuck high");
  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl)
    else $error("data pin changed while serial clock high");
  a_open_drain: assert property (!sda_out && !line_out)
    else $error("open drain pin driven high");
  a_reset_quiet: assert property ($rose(nrst) |->
    sda_oe_n && line_oe_n && !line_busy_flag)
    else $error("outputs not idle after reset");
endmodule

bind icb_bridge icb_bridge_properties icb_bridge_properties_inst (
  .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .line_in(line_in), .line_out(line_out),
  .line_oe_n(line_oe_n), .line_busy_flag(line_busy_flag)
);

// ===== bench/icb_host.sv
// Serial bus host model: start, stop and byte transfers
module icb_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_rel
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus idle at time zero; clock driven push-pull, never released
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Quarter bit of 8 cycles keeps each clock phase above ten cycles
  task automatic q();
    repeat (8) @(posedge clk);
    #1;
  endtask

  // Start, or repeated start when the clock is low
  task automatic start();
    sda_rel = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask

  task automatic stop();
    sda_rel = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b1;
    q();
  endtask

  // One clock pulse: data set in the low phase, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask

  // Eight bits MSB first, then the acknowledge pulse
  task automatic xfer(input logic [7:0] d, input logic mack,
    output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(mack, b);
    ack = !b;
  endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench of the serial command bridge
`include "icb_params.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, scl, sda_rel, sda, sda_out, sda_oe_n;
  logic line_in, line_out, line_oe_n, busy, slave_pull;
  int failures = 0, num_checks = 0, pull_ns = 30000, idx = 0;
  int seed;
  logic sbits[$];
  logic [7:0] ptr = `ICB_PTR_STATUS, rdata_m, rbyte, smask = 8'h01;
  logic [3:0][7:0] cfg_m = `ICB_CFG_RST;
  logic busy_m = 1'b0, pres_m = 1'b0, bit_m = 1'b0;
  logic [7:0] codes[5] = '{8'hb4, 8'h87, 8'ha5, 8'h96, 8'hc3};

  // Open-drain wires with pull-ups
  assign sda = sda_rel & (sda_oe_n | sda_out);
  assign line_in = (line_oe_n | line_out) & ~slave_pull;

  icb_bridge icb_bridge_inst (.clk(clk), .nrst(nrst), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n),
    .line_busy_flag(busy));
  icb_host icb_host_inst (.clk(clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));

  initial begin
    clk = 1'b0;
    slave_pull = 1'b0;
    forever #5 clk = ~clk;
  end

  // Line slave: a zero bit holds the line low for pull_ns after each pull
  always @(negedge line_oe_n) begin
    if (sbits.size() > 0) begin
      if (sbits.pop_front() == 1'b0) begin
        #1 slave_pull = 1'b1;
        #(pull_ns) slave_pull = 1'b0;
      end
    end
  end

  // ------------------------------------------------
  // Reference model of pointer, parameters and status
  // ------------------------------------------------
  function automatic logic [7:0] model_byte();
    logic [7:0] v;
    case (ptr)
      `ICB_PTR_STATUS: v = {2'b00, bit_m, 3'b000, pres_m, busy_m};
      `ICB_PTR_RDATA: v = rdata_m;
      default: begin
        v = cfg_m[idx];
        idx = (idx + 1) % 4;
      end
    endcase
    return v;
  endfunction

  function automatic void apply(input logic [7:0] c, input logic [7:0] p);
    idx = 0;
    if (c == `ICB_CMD_SET_PTR) begin
      ptr = p;
    end else if (c == `ICB_CMD_PORT_ADJ) begin
      ptr = `ICB_PTR_CONFIG;
      cfg_m[p[7:6]] = {2'b00, p[5:0]};
    end else begin
      busy_m = 1'b1;
    end
  endfunction

  // Write access: code and optional parameter, acknowledges compared
  task automatic wr(input logic [7:0] c, input logic [7:0] p, input bit hp,
    input logic ec, input logic ep);
    logic [7:0] r;
    logic a;
    icb_host_inst.start();
    icb_host_inst.xfer({`ICB_SLAVE_ADDR, 1'b0}, 1'b1, r, a);
    `CHK(a, 1'b1)
    icb_host_inst.xfer(c, 1'b1, r, a);
    `CHK(a, ec)
    if (hp && a === 1'b1) begin
      icb_host_inst.xfer(p, 1'b1, r, a);
      `CHK(a, ep)
    end
    icb_host_inst.stop(); // leave at once after a refusal
    if (ec && (!hp || ep)) begin
      apply(c, p);
    end
  endtask

  // Read access of n bytes, host refuses the last one
  task automatic rd(input int n);
    logic [7:0] r, m;
    logic a;
    icb_host_inst.start();
    icb_host_inst.xfer({`ICB_SLAVE_ADDR, 1'b1}, 1'b1, r, a);
    `CHK(a, 1'b1)
    m = (ptr == `ICB_PTR_STATUS) ? smask : 8'hff;
    for (int i = 0; i < n; i++) begin
      icb_host_inst.xfer(8'hff, i == n - 1, r, a);
      `CHK(r & m, model_byte() & m)
    end
    icb_host_inst.stop();
  endtask

  // Status polled in one access until busy clears, bounded
  task automatic poll();
    logic [7:0] r;
    logic a;
    int k;
    icb_host_inst.start();
    icb_host_inst.xfer({`ICB_SLAVE_ADDR, 1'b1}, 1'b1, r, a);
    k = 0;
    do begin
      icb_host_inst.xfer(8'hff, 1'b0, r, a);
      k++;
    end while (r[0] !== 1'b0 && k < 300);
    busy_m = 1'b0;
    icb_host_inst.xfer(8'hff, 1'b1, r, a);
    `CHK(r & smask, model_byte() & smask) // same register again
    icb_host_inst.stop();
  endtask

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog: the tests need about 1.1 ms
  initial begin
    #3000000;
    failures++;
    results();
  end

  initial begin
    seed = 32'h4fa9a317;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    rd(2); // status after reset, read twice
    wr(`ICB_CMD_SET_PTR, `ICB_PTR_CONFIG, 1, 1, 1);
    rd(5); // parameters in turn, wrapping
    wr(`ICB_CMD_PORT_ADJ, 8'h14, 1, 1, 1);
    rd(5); // pointer left on parameters
    wr(8'h00, 8'h00, 0, 0, 0); // unknown code
    wr(`ICB_CMD_SET_PTR, 8'h55, 1, 1, 0); // bad pointer code
    $display("test config done");
    wr(`ICB_CMD_SET_PTR, `ICB_PTR_STATUS, 1, 1, 1);
    rbyte = $random(seed);
    for (int i = 0; i < 8; i++) sbits.push_back(rbyte[i]);
    wr(`ICB_CMD_RD_BYTE, 8'h00, 0, 1, 0);
    rd(1); // busy seen right after the code
    foreach (codes[i]) wr(codes[i], 8'h01, 1, 0, 0); // refused
    wr(`ICB_CMD_SET_PTR, `ICB_PTR_RDATA, 1, 1, 1); // during the read
    repeat (55000) @(posedge clk); // eight 70 us slots
    busy_m = 1'b0;
    rdata_m = rbyte;
    rd(2); // received byte
    $display("test byte read done");
    wr(`ICB_CMD_SET_PTR, `ICB_PTR_STATUS, 1, 1, 1);
    sbits.push_back(1'b0);
    pull_ns = 155000;
    wr(`ICB_CMD_BUS_RST, 8'h00, 0, 1, 0);
    repeat (17000) @(posedge clk); // reset slot of 160 us
    busy_m = 1'b0;
    pres_m = 1'b1;
    smask = 8'h03;
    rd(1); // presence kept for a later read
    $display("test bus reset done");
    pull_ns = 30000;
    smask = 8'h21;
    for (int b = 0; b < 2; b++) begin
      sbits.push_back(b[0]);
      bit_m = b[0];
      wr(`ICB_CMD_BIT, 8'h80, 1, 1, 1);
      poll(); // result valid when busy falls
    end
    wr(`ICB_CMD_SET_PTR, `ICB_PTR_RDATA, 1, 1, 1);
    rd(1); // untouched by later slots
    $display("test single bit done");
    results();
  end
endmodule

// ===== design/icb_bridge.sv
// Serial-slave command bridge that runs a single-wire bus master
//
// Overview of operation
// - Port adjust leaves the read pointer on the port configuration register.
// - Successive configuration reads return the next port timing parameter.
// - While busy, refuse bus command codes with no acknowledge, start nothing.
// - Bus reset outcome stays in status for a later read.
// - Status readable while running; busy falls when the result is valid.
// - Byte write only sends; completion shown only by busy falling.
// - Byte read result held in read data register, selected by E1h.
// - Set read pointer accepted during a running byte read, no disturbance.
// - Serial clock is input only, never held low.
// - Repeated reads keep returning the selected register.
// - Acknowledge valid codes and parameters only, never extra bytes.
// - Codes: reset B4h, bit 87h, write A5h, read 96h, pointer E1h.
`include "icb_params.svh"
module icb_bridge
  import icb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_n,
  output logic line_busy_flag
);

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    icb_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic rw;
    logic acked;
    logic mack;
    logic [1:0] bidx;
    logic [7:0] cmd;
    logic [7:0] ptr;
    logic [1:0] cfg_idx;
    icb_cfg_t cfg;
    logic [7:0] rdata;
    logic busy;
    logic presence;
    logic bitres;
    logic start;
    icb_op_e kind;
    logic [7:0] wdata;
    logic sda_oe_n;
  } icb_top_s;

  icb_top_s r;
  icb_top_s n;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  icb_op_if op ();

  icb_line_op u_line (
    .clk(clk),
    .nrst(nrst),
    .line_in(line_in),
    .op(op.eng)
  );

  // ---------------------------------------------------------------
  // Bus conditions seen on the synchronised pins
  // ---------------------------------------------------------------
  assign scl_rise = r.scl_sy[1] && !r.scl_d;
  assign scl_fall = !r.scl_sy[1] && r.scl_d;
  assign start_cond = r.scl_sy[1] && r.scl_d && r.sda_d && !r.sda_sy[1];
  assign stop_cond = r.scl_sy[1] && r.scl_d && !r.sda_d && r.sda_sy[1];

  // ---------------------------------------------------------------
  // Next state: slave protocol, command decode, result capture
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] rd_byte;
    logic [7:0] status;
    rd_byte = 8'h00;
    status = 8'h00;
    n = r;
    n.start = 1'b0;
    // Clock is only ever sampled; no stretching path exists
    n.scl_sy = {r.scl_sy[0], scl};
    n.sda_sy = {r.sda_sy[0], sda_in};
    n.scl_d = r.scl_sy[1];
    n.sda_d = r.sda_sy[1];

    // Status stays readable while the engine runs
    status[`ICB_ST_BUSY] = r.busy;
    status[`ICB_ST_PRESENCE] = r.presence;
    status[`ICB_ST_BITRES] = r.bitres;
    unique case (r.ptr)
      `ICB_PTR_RDATA: rd_byte = r.rdata;
      `ICB_PTR_CONFIG: rd_byte = r.cfg[r.cfg_idx];
      default: rd_byte = status;
    endcase

    // Completion: busy falls with the result in place
    if (op.done) begin
      n.busy = 1'b0;
      if (r.kind == ICB_OP_RST) begin
        n.presence = !op.res;
      end
      if (r.kind == ICB_OP_BIT) begin
        n.bitres = op.res;
      end
      if (r.kind == ICB_OP_RD) begin
        n.rdata = op.rdata;
      end
    end

    if (start_cond) begin
      n.st = ICB_ADDR;
      n.cnt = 4'h0;
      n.sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      n.st = ICB_IDLE;
      n.sda_oe_n = 1'b1;
    end else begin
      unique case (r.st)
        ICB_IDLE: n.sda_oe_n = 1'b1;
        ICB_ADDR, ICB_WR: begin
          if (scl_rise) begin
            n.sh = {r.sh[6:0], r.sda_sy[1]};
            n.cnt = r.cnt + 4'h1;
          end else if (scl_fall && r.cnt == 4'h8) begin
            n.acked = 1'b0;
            if (r.st == ICB_ADDR) begin
              n.acked = (r.sh[7:1] == `ICB_SLAVE_ADDR);
              n.rw = r.sh[0];
              n.bidx = 2'h0;
            end else if (r.bidx == 2'h0) begin
              // Command code byte
              n.cmd = r.sh;
              unique case (r.sh)
                `ICB_CMD_SET_PTR: n.acked = 1'b1;
                `ICB_CMD_PORT_ADJ, `ICB_CMD_BIT, `ICB_CMD_WR_BYTE:
                  n.acked = !r.busy;
                `ICB_CMD_BUS_RST, `ICB_CMD_RD_BYTE: begin
                  n.acked = !r.busy;
                  if (!r.busy) begin
                    n.start = 1'b1;
                    n.busy = 1'b1;
                    n.kind = (r.sh == `ICB_CMD_BUS_RST) ? ICB_OP_RST
                                                         : ICB_OP_RD;
                  end
                end
                default: n.acked = 1'b0;
              endcase
            end else if (r.bidx == 2'h1) begin
              // Parameter byte; anything after it is refused
              unique case (r.cmd)
                `ICB_CMD_SET_PTR: begin
                  n.acked = (r.sh == `ICB_PTR_STATUS ||
                             r.sh == `ICB_PTR_RDATA ||
                             r.sh == `ICB_PTR_CONFIG);
                  if (n.acked) begin
                    n.ptr = r.sh;
                    n.cfg_idx = 2'h0;
                  end
                end
                `ICB_CMD_PORT_ADJ: begin
                  n.acked = 1'b1;
                  n.cfg[r.sh[`ICB_ADJ_SEL_HI:`ICB_ADJ_SEL_LO]] =
                    {2'h0, r.sh[`ICB_ADJ_VAL_HI:0]};
                  n.ptr = `ICB_PTR_CONFIG;
                  n.cfg_idx = 2'h0;
                end
                `ICB_CMD_BIT, `ICB_CMD_WR_BYTE: begin
                  n.acked = 1'b1;
                  n.start = 1'b1;
                  n.busy = 1'b1;
                  n.wdata = r.sh;
                  // Write only sends; read data is left alone
                  n.kind = (r.cmd == `ICB_CMD_BIT) ? ICB_OP_BIT : ICB_OP_WR;
                end
                default: n.acked = 1'b0;
              endcase
            end
            // Only data bytes advance the index; the address byte leaves
            // it at zero so the next byte is always the command code
            if (r.st == ICB_WR && r.bidx != 2'h3) begin
              n.bidx = r.bidx + 2'h1;
            end
            n.st = n.acked ? ICB_ACK : ICB_IDLE;
            n.sda_oe_n = !n.acked;
          end
        end
        ICB_ACK: begin
          if (scl_fall) begin
            n.cnt = 4'h0;
            if (r.rw && r.bidx == 2'h0) begin
              // Pointer is kept, so every read repeats its register
              n.st = ICB_RD;
              n.tx = rd_byte;
              n.sda_oe_n = rd_byte[7];
              if (r.ptr == `ICB_PTR_CONFIG) begin
                n.cfg_idx = r.cfg_idx + 2'h1;
              end
            end else begin
              n.st = ICB_WR;
              n.sda_oe_n = 1'b1;
            end
          end
        end
        ICB_RD: begin
          if (scl_fall) begin
            n.cnt = r.cnt + 4'h1;
            n.tx = {r.tx[6:0], 1'b1};
            n.sda_oe_n = r.tx[6];
            if (r.cnt == 4'h7) begin
              n.st = ICB_RACK;
              n.sda_oe_n = 1'b1;
            end
          end
        end
        ICB_RACK: begin
          if (scl_rise) begin
            n.mack = !r.sda_sy[1];
          end else if (scl_fall) begin
            n.cnt = 4'h0;
            n.st = r.mack ? ICB_RD : ICB_IDLE;
            n.tx = rd_byte;
            n.sda_oe_n = r.mack ? rd_byte[7] : 1'b1;
            if (r.mack && r.ptr == `ICB_PTR_CONFIG) begin
              n.cfg_idx = r.cfg_idx + 2'h1;
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{scl_sy: 2'h3, sda_sy: 2'h3, scl_d: 1'b1, sda_d: 1'b1,
             st: ICB_IDLE, cnt: 4'h0, sh: 8'h00, tx: 8'h00, rw: 1'b0,
             acked: 1'b0, mack: 1'b0, bidx: 2'h0, cmd: 8'h00,
             ptr: `ICB_PTR_STATUS, cfg_idx: 2'h0, cfg: `ICB_CFG_RST,
             rdata: 8'h00, busy: 1'b0, presence: 1'b0, bitres: 1'b0,
             start: 1'b0, kind: ICB_OP_RST, wdata: 8'h00, sda_oe_n: 1'b1};
    end else begin
      r <= n;
    end
  end

  // ---------------------------------------------------------------
  // Engine requests and pins from flip-flops; sda_out and line_out tied low
  // ---------------------------------------------------------------
  assign op.start = r.start;
  assign op.kind = r.kind;
  assign op.wdata = r.wdata;
  assign op.cfg = r.cfg;
  assign sda_out = 1'b0; // Open drain: only ever pulls low
  assign sda_oe_n = r.sda_oe_n;
  assign line_out = 1'b0;
  assign line_oe_n = op.line_oe_n;
  assign line_busy_flag = r.busy;

endmodule

// ===== design/icb_line_op.sv
// Single-wire line engine: reset, bit and byte slots with adjustable timing
`include "icb_params.svh"
module icb_line_op
  import icb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic line_in,
  icb_op_if.eng op
);

  typedef struct packed {
    logic [1:0] line_sy;
    icb_eng_e st;
    icb_op_e kind;
    logic [6:0] pre;
    logic [11:0] t;
    logic [2:0] nbit;
    logic [7:0] sh;
    logic res;
    logic done;
    logic oe_n;
  } icb_eng_s;

  icb_eng_s r;
  icb_eng_s n;
  logic [11:0] low_us;
  logic [11:0] samp_us;
  logic [11:0] end_us;

  // ---------------------------------------------------------------
  // Slot shape from the port timing parameters
  // ---------------------------------------------------------------
  always_comb begin
    if (r.kind == ICB_OP_RST) begin
      low_us = {2'h0, op.cfg[0], 2'h0};
      samp_us = low_us + 12'(`ICB_PRES_US);
      end_us = {low_us[10:0], 1'b0};
    end else begin
      // Reads use the short low time so the slave can answer
      low_us = (r.kind == ICB_OP_RD || r.sh[0]) ? {4'h0, op.cfg[2]}
                                                 : {4'h0, op.cfg[1]};
      samp_us = {4'h0, op.cfg[3]};
      end_us = 12'(`ICB_SLOT_US);
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.line_sy = {r.line_sy[0], line_in};
    unique case (r.st)
      ICB_E_IDLE: begin
        n.oe_n = 1'b1;
        if (op.start) begin
          n.st = ICB_E_RUN;
          n.kind = op.kind;
          n.pre = 7'h00;
          n.t = 12'h000;
          n.nbit = 3'h0;
          // The bit command carries its value in the top bit
          n.sh = (op.kind == ICB_OP_RD) ? 8'hff :
                 (op.kind == ICB_OP_BIT) ? {7'h00, op.wdata[7]} : op.wdata;
        end
      end
      ICB_E_RUN: begin
        n.oe_n = !(r.t < low_us);
        if (r.pre == 7'(`ICB_PRE_CYC - 1)) begin
          n.pre = 7'h00;
          n.t = r.t + 12'h001;
          if (r.t == samp_us) begin
            n.res = r.line_sy[1];
          end
          if (r.t == end_us) begin
            n.t = 12'h000;
            n.sh = {r.res, r.sh[7:1]};
            n.nbit = r.nbit + 3'h1;
            // Byte kinds run eight slots, least significant bit first
            if (r.kind == ICB_OP_RST || r.kind == ICB_OP_BIT ||
                r.nbit == 3'h7) begin
              n.st = ICB_E_IDLE;
              n.done = 1'b1;
              n.oe_n = 1'b1;
            end
          end
        end else begin
          n.pre = r.pre + 7'h01;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '{line_sy: 2'h3, st: ICB_E_IDLE, kind: ICB_OP_RST,
             pre: 7'h00, t: 12'h000, nbit: 3'h0, sh: 8'h00,
             res: 1'b1, done: 1'b0, oe_n: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign op.done = r.done;
  assign op.rdata = r.sh;
  assign op.res = r.res;
  assign op.line_oe_n = r.oe_n;

endmodule

// ===== design/icb_op_if.sv
// Carrier between the command interpreter and the line engine
interface icb_op_if;
  import icb_pkg::*;
  logic start;
  icb_op_e kind;
  logic [7:0] wdata;
  icb_cfg_t cfg;
  logic done;
  logic [7:0] rdata;
  logic res;
  logic line_oe_n;
  modport ctl (output start, output kind, output wdata, output cfg,
    input done, input rdata, input res, input line_oe_n);
  modport eng (input start, input kind, input wdata, input cfg,
    output done, output rdata, output res, output line_oe_n);
endinterface

// ===== design/icb_params.svh
// Constants of the command bridge: codes, pointers, bits, reset values, times
`ifndef ICB_PARAMS_SVH
`define ICB_PARAMS_SVH

// ---------------------------------------------------------------
// Serial slave address (arbitrary value)
// ---------------------------------------------------------------
`define ICB_SLAVE_ADDR 7'h18

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define ICB_CMD_SET_PTR 8'he1
`define ICB_CMD_PORT_ADJ 8'hc3
`define ICB_CMD_BUS_RST 8'hb4
`define ICB_CMD_BIT 8'h87
`define ICB_CMD_WR_BYTE 8'ha5
`define ICB_CMD_RD_BYTE 8'h96

// ---------------------------------------------------------------
// Read pointer codes
// ---------------------------------------------------------------
`define ICB_PTR_STATUS 8'hf0
`define ICB_PTR_RDATA 8'he1
`define ICB_PTR_CONFIG 8'hb4

// ---------------------------------------------------------------
// Status bit positions
// ---------------------------------------------------------------
`define ICB_ST_BUSY 0
`define ICB_ST_PRESENCE 1
`define ICB_ST_BITRES 5

// ---------------------------------------------------------------
// Port adjust parameter byte: [7:6] select, [5:0] value
// ---------------------------------------------------------------
`define ICB_ADJ_SEL_HI 7
`define ICB_ADJ_SEL_LO 6
`define ICB_ADJ_VAL_HI 5

// ---------------------------------------------------------------
// Port timing reset values (0: reset low in 4 us, 1: zero low us,
// 2: one low us, 3: sample point us)
// ---------------------------------------------------------------
`define ICB_CFG_RST {8'h0f, 8'h06, 8'h3c, 8'h78}

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ICB_CLK_NS 10
`define ICB_TICK_NS 1000
`define ICB_PRE_CYC (`ICB_TICK_NS / `ICB_CLK_NS)
`define ICB_SLOT_US 70
`define ICB_PRES_US 70

`endif

// ===== design/icb_pkg.sv
// Types shared by the command bridge modules
package icb_pkg;

  // Slave state of the serial host port
  typedef enum logic [5:0] {
    ICB_IDLE = 6'h01,
    ICB_ADDR = 6'h02,
    ICB_ACK = 6'h04,
    ICB_WR = 6'h08,
    ICB_RD = 6'h10,
    ICB_RACK = 6'h20
  } icb_state_e;

  // Line engine state
  typedef enum logic [1:0] {
    ICB_E_IDLE = 2'h1,
    ICB_E_RUN = 2'h2
  } icb_eng_e;

  // Kind of line operation
  typedef enum logic [1:0] {
    ICB_OP_RST = 2'h0,
    ICB_OP_BIT = 2'h1,
    ICB_OP_WR = 2'h2,
    ICB_OP_RD = 2'h3
  } icb_op_e;

  typedef logic [3:0][7:0] icb_cfg_t;

endpackage
